/* File: hw/sase_exec.sv */
// execution of literal_minus_accum, file_minus_accum and sleep entry, with AXI4-Lite registers
// Notes on behaviour
// - sleep: decode in Q1, idle in Q2 and Q3, enter sleep in Q4
// - sleep halts the core, oscillator stopped, until a wake-up arrives
// - sleep clears watchdog, sets time-out flag, clears power-down flag
// - literal_minus_accum writes literal minus accumulator into the accumulator
// - literal_minus_accum touches only carry, digit carry and zero
// - literal_minus_accum decoded by 11 110x over eight literal bits, bit 8 ignored
// - literal subtract phases: decode, read literal, process, write accumulator
// - carry is not-borrow; zero set only when the 8-bit result is zero
// - file_minus_accum: file register minus accumulator, 7-bit address, destination bit
// - destination bit 0 writes accumulator, 1 writes the file register back
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`include "sase_defines.svh"
`timescale 1ns/1ps
module sase_exec
  import sase_pkg::*;
#(
  parameter int AXI_AW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // instruction and register file
  input wire logic [13:0] instrWord,
  input wire logic [7:0] fileRdData,
  output sase_file_req_t fileReq,
  // power management
  input wire logic wakeReq,
  output logic oscStop,
  output logic watchdogCounterClr,
  output sase_phase_t qPhase,
  // axi4-lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  sase_phase_t phase_r, phase_nxt;
  sase_op_t op_r, op_nxt;
  sase_flags_t flags_r, flags_nxt;
  sase_file_req_t fileReq_r, fileReq_nxt;
  logic dest_r, dest_nxt;
  logic [7:0] lit_r, lit_nxt;
  logic [7:0] opnd_r, opnd_nxt;
  logic [7:0] accum_r, accum_nxt;
  logic [8:0] res_r, res_nxt;
  logic halfC_r, halfC_nxt, sleep_r, sleep_nxt, wdClr_r, wdClr_nxt, run_r, run_nxt;
  logic wakeMeta_r, wakeSync_r;
  logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, awRdy_r, awRdy_nxt, wRdy_r, wRdy_nxt;
  logic [7:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, arready_r, arready_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wrCommit, swAccumWr;
  logic [4:0] lowDiff;

  // wake pin synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wakeMeta_r <= 1'b0;
      wakeSync_r <= 1'b0;
    end else begin
      wakeMeta_r <= wakeReq;
      wakeSync_r <= wakeMeta_r;
    end
  end

  // software write commits once address and data are both held
  assign wrCommit = awHeld_r && wHeld_r && !bvalid_r;
  assign swAccumWr = wrCommit && awAddr_r == `SASE_ACCUM_OFS && wStrb_r[0];
  assign lowDiff = {1'b0, opnd_r[3:0]} + {1'b0, ~accum_r[3:0]} + 5'h01;

  // quarter-phase sequencer and datapath next state
  always_comb begin
    phase_nxt = phase_r;
    op_nxt = op_r;
    flags_nxt = flags_r;
    dest_nxt = dest_r;
    lit_nxt = lit_r;
    opnd_nxt = opnd_r;
    accum_nxt = accum_r;
    res_nxt = res_r;
    halfC_nxt = halfC_r;
    sleep_nxt = sleep_r;
    fileReq_nxt = fileReq_r;
    fileReq_nxt.we = 1'b0;
    wdClr_nxt = 1'b0;
    if (swAccumWr) begin
      accum_nxt = wData_r[7:0];
    end
    if (sleep_r) begin
      // clocks stopped; only a wake restarts at Q1
      if (wakeSync_r) begin
        sleep_nxt = 1'b0;
        phase_nxt = Q1;
      end
    end else begin
      case (phase_r)
        Q1: begin
          if (run_r) begin
            op_nxt = OP_NONE;
            lit_nxt = instrWord[7:0];
            dest_nxt = instrWord[`SASE_DEST_BIT];
            fileReq_nxt.addr = instrWord[6:0];
            if (instrWord[13:`SASE_LIT_POS] == `SASE_LIT_PAT) begin
              op_nxt = OP_LIT;
            end else if (instrWord[13:`SASE_FILE_POS] == `SASE_FILE_PAT) begin
              op_nxt = OP_FILE;
            end else if (instrWord == `SASE_SLEEP_CODE) begin
              op_nxt = OP_SLEEP;
            end
            phase_nxt = Q2;
          end
        end
        Q2: begin
          // read literal or file operand; sleep does nothing here
          opnd_nxt = (op_r == OP_FILE) ? fileRdData : lit_r;
          phase_nxt = Q3;
        end
        Q3: begin
          // operand minus accumulator, bit 8 is not-borrow
          res_nxt = {1'b0, opnd_r} + {1'b0, ~accum_r} + 9'h001;
          halfC_nxt = lowDiff[4];
          phase_nxt = Q4;
        end
        Q4: begin
          if (op_r == OP_LIT || op_r == OP_FILE) begin
            flags_nxt.carry = res_r[8];
            flags_nxt.digitCarryFlag = halfC_r;
            flags_nxt.zero = (res_r[7:0] == 8'h00);
            if (op_r == OP_FILE && dest_r) begin
              fileReq_nxt.we = 1'b1;
              fileReq_nxt.wdata = res_r[7:0];
            end else begin
              accum_nxt = res_r[7:0];
            end
          end else if (op_r == OP_SLEEP) begin
            sleep_nxt = 1'b1;
            wdClr_nxt = 1'b1;
            flags_nxt.timeoutStatusFlag = 1'b1;
            flags_nxt.powerdownStatusFlag = 1'b0;
          end
          phase_nxt = Q1;
        end
        default: phase_nxt = Q1;
      endcase
    end
  end

  // datapath registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_r <= Q1;
      op_r <= OP_NONE;
      flags_r <= '{timeoutStatusFlag: `SASE_TIMEOUT_RST, powerdownStatusFlag: `SASE_PWRDN_RST,
                   zero: 1'b0, digitCarryFlag: 1'b0, carry: 1'b0};
      dest_r <= 1'b0;
      lit_r <= 8'h00;
      opnd_r <= 8'h00;
      accum_r <= `SASE_ACCUM_RST;
      res_r <= 9'h000;
      halfC_r <= 1'b0;
      sleep_r <= 1'b0;
      fileReq_r <= '0;
      wdClr_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      op_r <= op_nxt;
      flags_r <= flags_nxt;
      dest_r <= dest_nxt;
      lit_r <= lit_nxt;
      opnd_r <= opnd_nxt;
      accum_r <= accum_nxt;
      res_r <= res_nxt;
      halfC_r <= halfC_nxt;
      sleep_r <= sleep_nxt;
      fileReq_r <= fileReq_nxt;
      wdClr_r <= wdClr_nxt;
    end
  end

  // axi4-lite write and read channels, next state
  always_comb begin
    awHeld_nxt = awHeld_r;
    awAddr_nxt = awAddr_r;
    wHeld_nxt = wHeld_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    run_nxt = run_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && !awHeld_r) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !wHeld_r) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    if (wrCommit) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = `SASE_RESP_OKAY;
      if (awAddr_r == `SASE_CTRL_OFS) begin
        if (wStrb_r[0]) run_nxt = wData_r[`SASE_RUN_BIT];
      end else if (awAddr_r != `SASE_STATUS_OFS && awAddr_r != `SASE_ACCUM_OFS) begin
        bresp_nxt = `SASE_RESP_SLVERR;
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = `SASE_RESP_OKAY;
      case (s_axi_araddr[7:0])
        `SASE_CTRL_OFS: rdata_nxt = {31'h0, run_r};
        `SASE_STATUS_OFS: rdata_nxt = {26'h0, sleep_r, flags_r};
        `SASE_ACCUM_OFS: rdata_nxt = {24'h0, accum_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = `SASE_RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    awRdy_nxt = !awHeld_nxt;
    wRdy_nxt = !wHeld_nxt;
  end

  // axi4-lite registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awHeld_r <= 1'b0;
      awRdy_r <= 1'b1;
      awAddr_r <= 8'h00;
      wHeld_r <= 1'b0;
      wRdy_r <= 1'b1;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      run_r <= `SASE_RUN_RST;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
    end else begin
      awHeld_r <= awHeld_nxt;
      awRdy_r <= awRdy_nxt;
      awAddr_r <= awAddr_nxt;
      wHeld_r <= wHeld_nxt;
      wRdy_r <= wRdy_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      run_r <= run_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // outputs straight from flops
  assign fileReq = fileReq_r;
  assign oscStop = sleep_r;
  assign watchdogCounterClr = wdClr_r;
  assign qPhase = phase_r;
  assign s_axi_awready = awRdy_r;
  assign s_axi_wready = wRdy_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // checks on phases, flags and destinations
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic subEnd;
  assign subEnd = !sleep_r && phase_r == Q4 && (op_r == OP_LIT || op_r == OP_FILE);

  a_sleep_entry: assert property (!sleep_r && phase_r == Q4 && op_r == OP_SLEEP |=>
    sleep_r && oscStop) else $error("sleep not entered at Q4");
  a_sleep_hold: assert property (sleep_r && !wakeSync_r |=> sleep_r && $stable(phase_r))
    else $error("core moved while asleep");
  a_sleep_flags: assert property ($rose(sleep_r) |-> flags_r.timeoutStatusFlag &&
    !flags_r.powerdownStatusFlag && watchdogCounterClr) else $error("sleep status wrong");
  a_lit_result: assert property (subEnd && op_r == OP_LIT && !swAccumWr |=>
    accum_r == 8'($past(opnd_r) - $past(accum_r))) else $error("literal result wrong");
  a_lit_status: assert property (subEnd && op_r == OP_LIT |=>
    $stable(flags_r.timeoutStatusFlag) && $stable(flags_r.powerdownStatusFlag))
    else $error("literal subtract touched power flags");
  a_lit_decode: assert property (!sleep_r && run_r && phase_r == Q1 &&
    instrWord[13:9] == 5'h1E |=> op_r == OP_LIT && lit_r == $past(instrWord[7:0]))
    else $error("literal opcode not decoded");
  a_phase_walk: assert property (!sleep_r && run_r && phase_r == Q1 |=>
    phase_r == Q2 ##1 phase_r == Q3 ##1 phase_r == Q4) else $error("phase order broken");
  a_borrow_flag: assert property (subEnd |=>
    flags_r.carry == ($past(opnd_r) >= $past(accum_r)) &&
    flags_r.zero == ($past(opnd_r) == $past(accum_r))) else $error("carry or zero wrong");
  a_file_addr: assert property (!sleep_r && run_r && phase_r == Q1 |=>
    fileReq.addr == $past(instrWord[6:0])) else $error("file address wrong");
  a_file_dest: assert property (subEnd && op_r == OP_FILE && dest_r |=> fileReq.we &&
    fileReq.wdata == 8'($past(opnd_r) - $past(accum_r)) && $stable(accum_r))
    else $error("file destination wrong");

  c_lit_sub: cover property (subEnd && op_r == OP_LIT ##1 flags_r.zero);
  c_file_back: cover property (subEnd && op_r == OP_FILE && dest_r);
  c_sleep_wake: cover property ($rose(sleep_r) ##[1:50] $fell(sleep_r));
  c_borrow: cover property (subEnd ##1 !flags_r.carry);
endmodule // sase_exec

/* File: pkg/sase_defines.svh */
// register offsets, reset values and opcode patterns of the subtract/sleep core
`ifndef SASE_DEFINES_SVH
`define SASE_DEFINES_SVH
`define SASE_CTRL_OFS 8'h00
`define SASE_STATUS_OFS 8'h04
`define SASE_ACCUM_OFS 8'h08
`define SASE_RUN_BIT 0
`define SASE_RUN_RST 1'b1
`define SASE_ACCUM_RST 8'h00
`define SASE_TIMEOUT_RST 1'b1
`define SASE_PWRDN_RST 1'b1
`define SASE_LIT_POS 9
`define SASE_LIT_PAT 5'h1E
`define SASE_FILE_POS 8
`define SASE_FILE_PAT 6'h02
`define SASE_DEST_BIT 7
`define SASE_SLEEP_CODE 14'h0063
`define SASE_RESP_OKAY 2'h0
`define SASE_RESP_SLVERR 2'h2
`endif

/* File: pkg/sase_pkg.sv */
// types of the subtract/sleep execution core
package sase_pkg;
  typedef enum logic [1:0] {Q1 = 2'b00, Q2 = 2'b01, Q3 = 2'b10, Q4 = 2'b11} sase_phase_t;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00, OP_LIT = 2'b01, OP_FILE = 2'b10, OP_SLEEP = 2'b11
  } sase_op_t;
  typedef struct packed {
    logic timeoutStatusFlag;
    logic powerdownStatusFlag;
    logic zero;
    logic digitCarryFlag;
    logic carry;
  } sase_flags_t;
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } sase_file_req_t;
endpackage

/* File: tb/test_subtract_and_sleep_exec.sv */
// self-checking bench of the subtract and sleep execution core
`include "sase_defines.svh"
`timescale 1ns/1ps
module test_subtract_and_sleep_exec;
  import sase_pkg::*;
  // core side
  logic clk, sys_rst, wakeReq, oscStop, watchdogCounterClr;
  logic [13:0] instrWord;
  logic [7:0] fileRdData;
  logic [7:0] fileMem [128];
  sase_file_req_t fileReq;
  sase_phase_t qPhase;
  // register bus
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int bad_count, comparisons;
  logic [2:0] stHi;

  // file register model, read without delay
  assign fileRdData = fileMem[fileReq.addr];

  sase_exec #(.AXI_AW(8)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .instrWord(instrWord), .fileRdData(fileRdData),
    .fileReq(fileReq), .wakeReq(wakeReq), .oscStop(oscStop),
    .watchdogCounterClr(watchdogCounterClr), .qPhase(qPhase),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stuck(input string what);
    bad_count++;
    $display("[FAIL] %s expected answer seen timeout", what);
    give_verdict();
  endtask

  // one write, address and data offered together
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 40) stuck("write");
  endtask

  // one read
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 40) stuck("read");
  endtask

  // present one instruction for the coming Q1, return Q2 address and next-Q1 request
  task automatic exec(input logic [13:0] ins, output logic [6:0] aSeen, output sase_file_req_t q);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (qPhase !== Q4 && n < 8);
    if (n == 8) stuck("phase");
    instrWord <= ins;
    @(posedge clk);
    instrWord <= 14'h0000;
    @(posedge clk);
    aSeen = fileReq.addr;
    repeat (2) @(posedge clk);
    #1;
    q = fileReq;
  endtask

  task automatic lit_case(input logic [7:0] k, input logic [7:0] w, input logic b8);
    logic [1:0] r;
    logic [31:0] d;
    logic [6:0] a;
    sase_file_req_t q;
    logic [7:0] res;
    res = k - w;
    axi_write(`SASE_ACCUM_OFS, {24'h0, w}, r);
    exec({`SASE_LIT_PAT, b8, k}, a, q);
    check("lit file we", 32'h0, {31'h0, q.we});
    axi_read(`SASE_ACCUM_OFS, d, r);
    check("lit accum", {24'h0, res}, d);
    axi_read(`SASE_STATUS_OFS, d, r);
    check("lit status", {26'h0, stHi, res == 8'h00, k[3:0] >= w[3:0], k >= w}, d);
  endtask

  task automatic file_case(input logic [6:0] a, input logic [7:0] f, input logic [7:0] w,
                           input logic dst);
    logic [1:0] r;
    logic [31:0] d;
    logic [6:0] aSeen;
    sase_file_req_t q;
    logic [7:0] res;
    res = f - w;
    fileMem[a] <= f;
    axi_write(`SASE_ACCUM_OFS, {24'h0, w}, r);
    exec({`SASE_FILE_PAT, dst, a}, aSeen, q);
    check("file addr", {25'h0, a}, {25'h0, aSeen});
    check("file we", {31'h0, dst}, {31'h0, q.we});
    if (dst) check("file wdata", {24'h0, res}, {24'h0, q.wdata});
    @(posedge clk);
    #1;
    check("file we pulse", 32'h0, {31'h0, fileReq.we});
    axi_read(`SASE_ACCUM_OFS, d, r);
    check("file accum", {24'h0, dst ? w : res}, d);
    axi_read(`SASE_STATUS_OFS, d, r);
    check("file status", {26'h0, stHi, res == 8'h00, f[3:0] >= w[3:0], f >= w}, d);
  endtask

  task automatic sleep_case();
    logic [1:0] r;
    logic [31:0] d;
    logic [6:0] a;
    sase_file_req_t q;
    int n;
    axi_write(`SASE_ACCUM_OFS, 32'h5A, r);
    exec(`SASE_SLEEP_CODE, a, q);
    check("sleep osc", 32'h1, {31'h0, oscStop});
    check("sleep watchdog clear", 32'h1, {31'h0, watchdogCounterClr});
    @(posedge clk);
    instrWord <= {`SASE_LIT_PAT, 1'b0, 8'h77};
    #1;
    check("watchdog clear pulse", 32'h0, {31'h0, watchdogCounterClr});
    repeat (8) @(posedge clk);
    instrWord <= 14'h0000;
    check("asleep osc", 32'h1, {31'h0, oscStop});
    axi_read(`SASE_STATUS_OFS, d, r);
    check("sleep status", 32'h6, {29'h0, d[5:3]});
    @(posedge clk);
    wakeReq <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (oscStop !== 1'b0 && n < 10);
    if (n == 10) stuck("wake");
    check("wake phase", {30'h0, Q1}, {30'h0, qPhase});
    @(posedge clk);
    wakeReq <= 1'b0;
    axi_read(`SASE_ACCUM_OFS, d, r);
    check("asleep accum", 32'h5A, d);
    stHi = 3'b010;
    lit_case(8'h30, 8'h5A, 1'b1);
  endtask

  // run cleared parks the core at Q1; status writes are ignored
  task automatic hold_case();
    logic [1:0] r;
    logic [31:0] d;
    axi_write(`SASE_ACCUM_OFS, 32'h11, r);
    check("accum bresp", {30'h0, `SASE_RESP_OKAY}, {30'h0, r});
    axi_write(`SASE_CTRL_OFS, 32'h0, r);
    instrWord <= {`SASE_LIT_PAT, 1'b0, 8'h99};
    repeat (6) @(posedge clk);
    #1;
    check("held phase", {30'h0, Q1}, {30'h0, qPhase});
    @(posedge clk);
    instrWord <= 14'h0000;
    axi_read(`SASE_ACCUM_OFS, d, r);
    check("held accum", 32'h11, d);
    axi_read(`SASE_CTRL_OFS, d, r);
    check("run off", 32'h0, d);
    axi_write(`SASE_STATUS_OFS, 32'h0, r);
    check("status bresp", {30'h0, `SASE_RESP_OKAY}, {30'h0, r});
    axi_read(`SASE_STATUS_OFS, d, r);
    check("status kept", 32'h18, d);
    axi_write(`SASE_CTRL_OFS, 32'h1, r);
    axi_read(`SASE_CTRL_OFS, d, r);
    check("run on", 32'h1, d);
  endtask

  // reset, then the scenarios in turn
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    sys_rst = 1'b1;
    {wakeReq, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {instrWord, awaddr, araddr, wdata} = 62'h0;
    bad_count = 0;
    comparisons = 0;
    stHi = 3'b011;
    for (int i = 0; i < 128; i++) fileMem[i] = 8'h00;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    axi_read(`SASE_STATUS_OFS, d, r);
    check("reset status", 32'h18, d);
    axi_write(8'h0C, 32'hFF, r);
    check("unmapped bresp", {30'h0, `SASE_RESP_SLVERR}, {30'h0, r});
    axi_read(8'h0C, d, r);
    check("unmapped rresp", {30'h0, `SASE_RESP_SLVERR}, {30'h0, r});
    check("unmapped rdata", 32'h0, d);
    hold_case();
    lit_case(8'h02, 8'h01, 1'b0);
    lit_case(8'h02, 8'h02, 1'b1);
    lit_case(8'h02, 8'h03, 1'b0);
    lit_case(8'h10, 8'h01, 1'b1);
    lit_case(8'hFF, 8'h00, 1'b0);
    lit_case(8'h00, 8'hFF, 1'b1);
    file_case(7'h7F, 8'h03, 8'h02, 1'b1);
    file_case(7'h00, 8'h01, 8'h02, 1'b0);
    file_case(7'h40, 8'h02, 8'h02, 1'b1);
    sleep_case();
    give_verdict();
  end
endmodule // test_subtract_and_sleep_exec
